// ### dfg_regs.svh
// register offsets, field positions, reset values for the dual port f/g block
`ifndef DFG_REGS_SVH
`define DFG_REGS_SVH

// ------------------------------------------------------------
// register offsets (byte address on the plain register port)
// ------------------------------------------------------------
`define DFG_ADDR_F_DIR       4'h0
`define DFG_ADDR_F_PINS      4'h1
`define DFG_ADDR_F_LATCH     4'h2
`define DFG_ADDR_G_DIR       4'h3
`define DFG_ADDR_G_PINS      4'h4
`define DFG_ADDR_G_LATCH     4'h5
`define DFG_ADDR_ANALOG_CFG  4'h6
`define DFG_ADDR_CMP_CTRL    4'h7
`define DFG_ADDR_CMP_REF     4'h8

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DFG_RST_F_DIR        8'hFF
`define DFG_RST_G_DIR        5'h1F
`define DFG_RST_LATCH        8'h00
`define DFG_RST_CFG          8'h00

// ------------------------------------------------------------
// field positions and codes
// ------------------------------------------------------------
`define DFG_ADC_DIGITAL      4'hF
`define DFG_CMP_MODE_OFF     3'h7
`define DFG_CMP_MODE_OUT     3'h3
`define DFG_CMP_RO_LSB       6
`define DFG_CVR_EN_BIT       7
`define DFG_CVR_OE_BIT       6
`define DFG_G_MASTER_CLEAR_INPUT_BIT       5

`endif

// ### dfg_pkg.sv
// types shared by the dual port f/g block
package dfg_pkg;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dfg_bus_req_t;

  // peripheral side signals that may take over pins
  typedef struct packed {
    logic cmp_one;        // comparator one output
    logic cmp_two;        // comparator two output
    logic ssp_ss_en;      // serial port slave select in use
    logic can_en;         // can peripheral owns g0..g2
    logic can_tx;         // can transmit level
    logic can_tx_comp;    // complementary can transmit level
    logic can_clk_sel;    // g1 carries bit-time clock
    logic can_bit_clk;    // can bit-time clock
    logic pwm_d_en;       // pwm output d owns g4
    logic pwm_d;          // pwm output d level
  } dfg_periph_t;

  // whole state of the port block
  typedef struct packed {
    logic [7:0] f_dir;
    logic [7:0] f_lat;
    logic [4:0] g_dir;
    logic [4:0] g_lat;
    logic [7:0] adcfg;
    logic [7:0] comparator_control;
    logic [7:0] comparator_reference_control;
    logic [7:0] f_s1;
    logic [7:0] f_s2;
    logic [5:0] g_s1;
    logic [5:0] g_s2;
    logic [7:0] rdata;
    logic [7:0] f_out;
    logic [7:0] f_oen;
    logic [5:0] g_out;
    logic [5:0] g_oen;
    logic       can_rx;
    logic       ss;
    logic       master_clear_input;
  } dfg_state_t;

endpackage : dfg_pkg

// ### dfg_port.sv
// dual general-purpose port f (8 bit) and g (6 bit) with peripheral muxing
`include "dfg_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module dfg_port (
  input  wire logic                 clk_sys_in,           // system clock, 100 MHz
  input  wire logic                 reset_in,             // synchronous reset, active high
  input  wire logic                 reset_is_por_in,      // reset is power-on or brown-out
  input  wire logic                 master_clear_enable_cfg_in, // g5 used as master clear
  input  wire dfg_pkg::dfg_bus_req_t bus_in,              // register port request
  output logic [7:0]                rdata_out,            // read data, cycle after read
  input  wire dfg_pkg::dfg_periph_t periph_in,            // peripheral takeover signals
  input  wire logic [7:0]           port_f_pin_in,        // port f pin levels
  output logic [7:0]                port_f_pin_out,       // port f drive levels
  output logic [7:0]                port_f_pin_oe_n_out,  // port f enable, low drives
  input  wire logic [5:0]           port_g_pin_in,        // port g pin levels
  output logic [5:0]                port_g_pin_out,       // port g drive levels
  output logic [5:0]                port_g_pin_oe_n_out,  // port g enable, low drives
  output logic                      can_receive_out,      // can receive level to can
  output logic                      port_f_bit7_pin_out,  // slave select level to serial port
  output logic                      master_clear_input_out // master clear level, high idle
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  dfg_pkg::dfg_state_t st_reg;
  dfg_pkg::dfg_state_t st_next;

  logic       cmp_in_sel;
  logic       cmp_out_sel;
  logic       cvref_out;
  logic       adc_dig;
  logic [7:0] f_drv_en;
  logic [7:0] f_drv_val;
  logic [7:0] f_dig;
  logic [5:0] g_drv_en;
  logic [5:0] g_drv_val;
  logic [7:0] rd_val;

  // ------------------------------------------------------------
  // pin function selection
  // ------------------------------------------------------------
  // configuration decode shared by the port f pins
  assign cmp_in_sel  = st_reg.comparator_control[2:0] != `DFG_CMP_MODE_OFF;
  assign cmp_out_sel = st_reg.comparator_control[2:0] == `DFG_CMP_MODE_OUT;
  assign cvref_out   = st_reg.comparator_reference_control[`DFG_CVR_EN_BIT] & st_reg.comparator_reference_control[`DFG_CVR_OE_BIT];
  assign adc_dig     = st_reg.adcfg[3:0] == `DFG_ADC_DIGITAL;

  genvar i;
  // port f per-bit driver and read masks
  generate
    for (i = 0; i < 8; i++) begin : g_f_bit
      logic ovr_in;
      logic ovr_out;
      logic analog;
      assign ovr_out = ((i == 1) || (i == 2)) && cmp_out_sel;
      assign ovr_in  = ((i >= 3) && (i <= 6) && cmp_in_sel) || ((i == 5) && cvref_out)
                       || ((i == 7) && periph_in.ssp_ss_en);
      assign analog  = (i < 7) && (!adc_dig || ((i >= 3) && cmp_in_sel) || ((i == 5) && cvref_out));
      assign f_drv_en[i]  = ovr_out | (~ovr_in & ~st_reg.f_dir[i]);
      assign f_drv_val[i] = ovr_out ? ((i == 1) ? periph_in.cmp_two : periph_in.cmp_one)
                                    : st_reg.f_lat[i];
      assign f_dig[i]     = ~analog;
    end
  endgenerate

  // port g per-bit driver; bit 5 has no driver at all
  generate
    for (i = 0; i < 5; i++) begin : g_g_bit
      logic ovr_in;
      logic ovr_out;
      logic ovr_val;
      assign ovr_out = (((i == 0) || (i == 1)) && periph_in.can_en)
                       || ((i == 4) && periph_in.pwm_d_en);
      assign ovr_in  = (i == 2) && periph_in.can_en;
      assign ovr_val = (i == 0) ? periph_in.can_tx :
                       (i == 1) ? (periph_in.can_clk_sel ? periph_in.can_bit_clk
                                                         : periph_in.can_tx_comp) :
                       periph_in.pwm_d;
      assign g_drv_en[i]  = ovr_out | (~ovr_in & ~st_reg.g_dir[i]);
      assign g_drv_val[i] = ovr_out ? ovr_val : st_reg.g_lat[i];
    end
  endgenerate
  assign g_drv_en[5]  = 1'b0;
  assign g_drv_val[5] = 1'b0;

  // ------------------------------------------------------------
  // read data mux
  // ------------------------------------------------------------
  // registered next cycle; unmapped offsets read zero
  always_comb begin
    case (bus_in.addr)
      `DFG_ADDR_F_DIR:      rd_val = st_reg.f_dir;
      `DFG_ADDR_F_PINS:     rd_val = st_reg.f_s2 & f_dig;
      `DFG_ADDR_F_LATCH:    rd_val = st_reg.f_lat;
      `DFG_ADDR_G_DIR:      rd_val = {3'h1, st_reg.g_dir};
      `DFG_ADDR_G_PINS:     rd_val = {2'h0, st_reg.g_s2[5] & ~master_clear_enable_cfg_in,
                                      st_reg.g_s2[4:0]};
      `DFG_ADDR_G_LATCH:    rd_val = {3'h0, st_reg.g_lat};
      `DFG_ADDR_ANALOG_CFG: rd_val = st_reg.adcfg;
      `DFG_ADDR_CMP_CTRL:   rd_val = {periph_in.cmp_two, periph_in.cmp_one, st_reg.comparator_control[5:0]};
      `DFG_ADDR_CMP_REF:    rd_val = st_reg.comparator_reference_control;
      default:              rd_val = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // pin sampling, two stages
    st_next.f_s1 = port_f_pin_in;
    st_next.f_s2 = st_reg.f_s1;
    st_next.g_s1 = port_g_pin_in;
    st_next.g_s2 = st_reg.g_s1;
    st_next.rdata = bus_in.rd ? rd_val : 8'h00;
    // software writes; pin register writes go to the latch
    if (bus_in.wr) begin
      case (bus_in.addr)
        `DFG_ADDR_F_DIR:      st_next.f_dir = bus_in.wdata;
        `DFG_ADDR_F_PINS:     st_next.f_lat = bus_in.wdata;
        `DFG_ADDR_F_LATCH:    st_next.f_lat = bus_in.wdata;
        `DFG_ADDR_G_DIR:      st_next.g_dir = bus_in.wdata[4:0];
        `DFG_ADDR_G_PINS:     st_next.g_lat = bus_in.wdata[4:0];
        `DFG_ADDR_G_LATCH:    st_next.g_lat = bus_in.wdata[4:0];
        `DFG_ADDR_ANALOG_CFG: st_next.adcfg = bus_in.wdata;
        `DFG_ADDR_CMP_CTRL:   st_next.comparator_control = {2'h0, bus_in.wdata[5:0]};
        `DFG_ADDR_CMP_REF:    st_next.comparator_reference_control = bus_in.wdata;
        default:              st_next.rdata = st_next.rdata;
      endcase
    end
    // registered pin drivers and peripheral inputs
    st_next.f_out  = f_drv_val;
    st_next.f_oen  = ~f_drv_en;
    st_next.g_out  = g_drv_val;
    st_next.g_oen  = ~g_drv_en;
    st_next.can_rx = st_reg.g_s2[2];
    st_next.ss     = periph_in.ssp_ss_en ? st_reg.f_s2[7] : 1'b1;
    st_next.master_clear_input   = master_clear_enable_cfg_in ? st_reg.g_s2[`DFG_G_MASTER_CLEAR_INPUT_BIT] : 1'b1;
    // reset: directions all input, latch kept unless power-on
    if (reset_in) begin
      st_next.f_dir  = `DFG_RST_F_DIR;
      st_next.g_dir  = `DFG_RST_G_DIR;
      st_next.adcfg  = `DFG_RST_CFG;
      st_next.comparator_control  = `DFG_RST_CFG;
      st_next.comparator_reference_control = `DFG_RST_CFG;
      st_next.rdata  = 8'h00;
      st_next.f_out  = 8'h00;
      st_next.f_oen  = 8'hFF;
      st_next.g_out  = 6'h00;
      st_next.g_oen  = 6'h3F;
      st_next.can_rx = 1'b1;
      st_next.ss     = 1'b1;
      st_next.master_clear_input   = 1'b1;
      if (reset_is_por_in) begin
        st_next.f_lat = `DFG_RST_LATCH;
        st_next.g_lat = 5'h00;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    st_reg <= st_next;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rdata_out              = st_reg.rdata;
  assign port_f_pin_out         = st_reg.f_out;
  assign port_f_pin_oe_n_out    = st_reg.f_oen;
  assign port_g_pin_out         = st_reg.g_out;
  assign port_g_pin_oe_n_out    = st_reg.g_oen;
  assign can_receive_out        = st_reg.can_rx;
  assign port_f_bit7_pin_out    = st_reg.ss;
  assign master_clear_input_out = st_reg.master_clear_input;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  // software write followed by a read of the same latch
  sequence s_f_latch_wr;
    bus_in.wr && (bus_in.addr == `DFG_ADDR_F_PINS);
  endsequence
  sequence s_f_latch_rd;
    bus_in.rd && (bus_in.addr == `DFG_ADDR_F_LATCH);
  endsequence

  property p_pins_wr_to_latch;
    logic [7:0] d;
    (s_f_latch_wr, d = bus_in.wdata) ##1 (s_f_latch_rd and !bus_in.wr) |=> rdata_out == d;
  endproperty
  a_pins_wr_to_latch: assert property (p_pins_wr_to_latch) else $error("pin write not in latch");

  property p_latch_read;
    s_f_latch_rd |=> rdata_out == $past(st_reg.f_lat);
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch read mismatch");

  property p_dir_read;
    (bus_in.rd && bus_in.addr == `DFG_ADDR_F_DIR) |=> rdata_out == $past(st_reg.f_dir);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read mismatch");

  property p_f_input;
    (st_reg.f_dir[0] && st_reg.f_dir[3]) |=> port_f_pin_oe_n_out[0] && port_f_pin_oe_n_out[3];
  endproperty
  a_f_input: assert property (p_f_input) else $error("input pin driven");

  property p_f_drive;
    (!st_reg.f_dir[0] && !cmp_in_sel) |=> !port_f_pin_oe_n_out[0]
      && (port_f_pin_out[0] == $past(st_reg.f_lat[0]));
  endproperty
  a_f_drive: assert property (p_f_drive) else $error("output pin not driving latch");

  property p_g5_off;
    port_g_pin_oe_n_out[5] && !port_g_pin_out[5];
  endproperty
  a_g5_off: assert property (p_g5_off) else $error("g5 driver enabled");

  property p_can_tx;
    periph_in.can_en |=> !port_g_pin_oe_n_out[0] && port_g_pin_oe_n_out[2]
      && (port_g_pin_out[0] == $past(periph_in.can_tx));
  endproperty
  a_can_tx: assert property (p_can_tx) else $error("can pins not taken over");

  property p_pwm_d;
    periph_in.pwm_d_en |=> !port_g_pin_oe_n_out[4] && (port_g_pin_out[4] == $past(periph_in.pwm_d));
  endproperty
  a_pwm_d: assert property (p_pwm_d) else $error("pwm d not on g4");

  property p_ss_input;
    // checked after two cycles of select; the level falls back to idle one cycle after select drops
    periph_in.ssp_ss_en ##1 periph_in.ssp_ss_en |-> port_f_pin_oe_n_out[7]
      ##1 port_f_bit7_pin_out == $past(st_reg.f_s2[7]);
  endproperty
  a_ss_input: assert property (p_ss_input) else $error("slave select pin driven");

  property p_dir_after_reset;
    $past(reset_in) |-> (st_reg.f_dir == `DFG_RST_F_DIR) && (port_g_pin_oe_n_out == 6'h3F);
  endproperty
  a_dir_after_reset: assert property (p_dir_after_reset) else $error("pins not input after reset");

  property p_por_latch;
    $past(reset_in && reset_is_por_in) |-> st_reg.f_lat == `DFG_RST_LATCH;
  endproperty
  a_por_latch: assert property (p_por_latch) else $error("latch not cleared at power-on");

  property p_analog_zero;
    (bus_in.rd && bus_in.addr == `DFG_ADDR_F_PINS && !adc_dig) |=> rdata_out[6:0] == 7'h00;
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

  property p_cmp_out;
    cmp_out_sel |=> !port_f_pin_oe_n_out[1] && (port_f_pin_out[2] == $past(periph_in.cmp_one));
  endproperty
  a_cmp_out: assert property (p_cmp_out) else $error("comparator output not on pin");

  // ------------------------------------------------------------
  // port g register reads and pin behaviour, then port f, g1 and read data checks
  // ------------------------------------------------------------
  // g direction read shows bit 5 as fixed input
  property p_g_dir_read;
    (bus_in.rd && bus_in.addr == `DFG_ADDR_G_DIR) |=> rdata_out == {3'h1, $past(st_reg.g_dir)};
  endproperty
  a_g_dir_read: assert property (p_g_dir_read) else $error("g direction read mismatch");

  // g latch read returns stored latch
  property p_g_latch_read;
    (bus_in.rd && bus_in.addr == `DFG_ADDR_G_LATCH) |=> rdata_out == {3'h0, $past(st_reg.g_lat)};
  endproperty
  a_g_latch_read: assert property (p_g_latch_read) else $error("g latch read mismatch");

  // g3 has no peripheral, direction alone rules it
  property p_g_input;
    st_reg.g_dir[3] |=> port_g_pin_oe_n_out[3];
  endproperty
  a_g_input: assert property (p_g_input) else $error("g input pin driven");

  // g3 output shows its latch bit
  property p_g_drive;
    !st_reg.g_dir[3] |=> !port_g_pin_oe_n_out[3] && (port_g_pin_out[3] == $past(st_reg.g_lat[3]));
  endproperty
  a_g_drive: assert property (p_g_drive) else $error("g output pin not driving latch");

  // can receive level is the g2 pin three edges back
  property p_can_rx_path;
    !$past(reset_in) |-> can_receive_out == $past(port_g_pin_in[2], 3);
  endproperty
  a_can_rx_path: assert property (p_can_rx_path) else $error("can receive level wrong");

  // master clear level idles high while disabled
  property p_master_clear_input_idle;
    (!$past(reset_in) && !$past(master_clear_enable_cfg_in)) |-> master_clear_input_out;
  endproperty
  a_master_clear_input_idle: assert property (p_master_clear_input_idle) else $error("master clear active while off");

  // g5 reads zero while serving as master clear
  property p_g5_read_masked;
    (bus_in.rd && bus_in.addr == `DFG_ADDR_G_PINS && master_clear_enable_cfg_in) |=> !rdata_out[5];
  endproperty
  a_g5_read_masked: assert property (p_g5_read_masked) else $error("g5 read while master clear");

  // peripheral takeover leaves the direction register alone
  property p_ovr_not_stored;
    (periph_in.can_en && !bus_in.wr) |=> st_reg.g_dir == $past(st_reg.g_dir);
  endproperty
  a_ovr_not_stored: assert property (p_ovr_not_stored) else $error("override stored in direction");

  // comparator inputs force f3..f6 to input
  property p_cmp_in_forced;
    cmp_in_sel |=> port_f_pin_oe_n_out[6:3] == 4'hF;
  endproperty
  a_cmp_in_forced: assert property (p_cmp_in_forced) else $error("comparator input pin driven");

  // reference output keeps f5 off the digital driver
  property p_cvref_in;
    cvref_out |=> port_f_pin_oe_n_out[5];
  endproperty
  a_cvref_in: assert property (p_cvref_in) else $error("reference pin driven");

  // g1 carries complementary transmit or bit clock
  property p_can_tx_comp;
    periph_in.can_en |=> !port_g_pin_oe_n_out[1] && (port_g_pin_out[1] == ($past(periph_in.can_clk_sel)
      ? $past(periph_in.can_bit_clk) : $past(periph_in.can_tx_comp)));
  endproperty
  a_can_tx_comp: assert property (p_can_tx_comp) else $error("g1 can output wrong");

  // read data stands one cycle only
  property p_rdata_idle;
    !bus_in.rd |=> rdata_out == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

  // all-digital pin read returns the synchronised levels
  property p_f_dig_read;
    (bus_in.rd && bus_in.addr == `DFG_ADDR_F_PINS && adc_dig && !cmp_in_sel && !cvref_out)
      |=> rdata_out == $past(st_reg.f_s2);
  endproperty
  a_f_dig_read: assert property (p_f_dig_read) else $error("digital pin read mismatch");

  // f7 input follows its direction bit
  property p_f7_input;
    st_reg.f_dir[7] |=> port_f_pin_oe_n_out[7];
  endproperty
  a_f7_input: assert property (p_f7_input) else $error("f7 input pin driven");

endmodule : dfg_port

`default_nettype wire

// ### dfg_pin_model.sv
// board-side pin model for the dual port f/g block
`timescale 1ns/10ps
`default_nettype none

module dfg_pin_model (
  input  wire logic [7:0] f_drive_in,  // block drive levels, port f
  input  wire logic [7:0] f_oe_n_in,   // low where the block drives, port f
  input  wire logic [7:0] f_board_in,  // board level on released f pins
  input  wire logic [5:0] g_drive_in,  // block drive levels, port g
  input  wire logic [5:0] g_oe_n_in,   // low where the block drives, port g
  input  wire logic [5:0] g_board_in,  // board level on released g pins
  output logic      [7:0] f_level_out, // resolved wire level, port f
  output logic      [5:0] g_level_out  // resolved wire level, port g
);
  // a driven pin shows the drive, a released pin the board level
  assign f_level_out = (f_oe_n_in & f_board_in) | (~f_oe_n_in & f_drive_in);
  assign g_level_out = (g_oe_n_in & g_board_in) | (~g_oe_n_in & g_drive_in);
endmodule : dfg_pin_model

`default_nettype wire

// ### tb_dfg_port.sv
// self-checking testbench for the dual port f/g block
`include "dfg_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_dfg_port;
  logic                  clk_sys_in, reset_in, por, mcle, can_rx, ss, master_clear_input;
  dfg_pkg::dfg_bus_req_t bus;
  dfg_pkg::dfg_periph_t  per;
  logic [7:0]            rdata, f_out, f_oen, f_in, f_ext;
  logic [5:0]            g_out, g_oen, g_in, g_ext;
  int                    mismatches, tests_run;

  // ------------------------------------------------------------
  // clock, design and board
  // ------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  dfg_port dut_u (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .reset_is_por_in(por),
    .master_clear_enable_cfg_in(mcle), .bus_in(bus), .rdata_out(rdata), .periph_in(per),
    .port_f_pin_in(f_in), .port_f_pin_out(f_out), .port_f_pin_oe_n_out(f_oen),
    .port_g_pin_in(g_in), .port_g_pin_out(g_out), .port_g_pin_oe_n_out(g_oen),
    .can_receive_out(can_rx), .port_f_bit7_pin_out(ss), .master_clear_input_out(master_clear_input));

  dfg_pin_model pins_u (.f_drive_in(f_out), .f_oe_n_in(f_oen), .f_board_in(f_ext),
    .g_drive_in(g_out), .g_oe_n_in(g_oen), .g_board_in(g_ext),
    .f_level_out(f_in), .g_level_out(g_in));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // compare and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys_in);
    bus <= '0;
  endtask : wr

  // one-cycle read, data looked at in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys_in);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys_in);
    bus <= '0;
    #1 chk(what, exp, rdata);
  endtask : rd

  // let pin changes pass the synchronisers and output flops
  task automatic settle;
    repeat (4) @(posedge clk_sys_in);
    #1;
  endtask : settle

  // reset held twelve cycles
  task automatic do_reset(input logic p);
    reset_in <= 1'b1;
    por      <= p;
    repeat (12) @(posedge clk_sys_in);
    reset_in <= 1'b0;
  endtask : do_reset

  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // hang guard
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    mismatches++;
    $display("BAD watchdog expected end seen hang");
    complete_run;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_in = 1'b1; por = 1'b1; mcle = 1'b0; bus = '0; per = '0;
    f_ext = 8'hFF; g_ext = 6'h3F; mismatches = 0; tests_run = 0;
    do_reset(1'b1);
    settle;
    chk("f oe_n", 8'hFF, f_oen);
    chk("g oe_n", 8'h3F, {2'b00, g_oen});
    rd(`DFG_ADDR_F_DIR, 8'hFF, "f dir");
    rd(`DFG_ADDR_G_DIR, 8'h3F, "g dir");
    rd(`DFG_ADDR_F_LATCH, 8'h00, "f latch");
    rd(`DFG_ADDR_F_PINS, 8'h80, "f pins analog");
    $display("test reset values done");
    // pin reads against latch reads
    wr(`DFG_ADDR_ANALOG_CFG, 8'h0F);
    wr(`DFG_ADDR_CMP_CTRL, 8'h07);
    wr(`DFG_ADDR_F_LATCH, 8'hA5);
    @(posedge clk_sys_in);
    f_ext <= 8'h3C;
    settle;
    rd(`DFG_ADDR_F_PINS, 8'h3C, "f pins");
    rd(`DFG_ADDR_F_LATCH, 8'hA5, "f latch");
    wr(`DFG_ADDR_F_PINS, 8'h81);
    rd(`DFG_ADDR_F_LATCH, 8'h81, "f latch via pins");
    wr(`DFG_ADDR_F_DIR, 8'h00);
    settle;
    chk("f out", 8'h81, f_out);
    chk("f oe_n", 8'h00, f_oen);
    rd(`DFG_ADDR_F_PINS, 8'h81, "f pins driven");
    $display("test port f latch done");
    // comparator outputs and slave select
    @(posedge clk_sys_in);
    per.cmp_one   <= 1'b1;
    per.ssp_ss_en <= 1'b1;
    f_ext         <= 8'h00;
    wr(`DFG_ADDR_CMP_CTRL, 8'h03);
    wr(`DFG_ADDR_F_DIR, 8'hFF);
    settle;
    chk("cmp pins", 8'h08, {4'h0, f_out[2:1], f_oen[2:1]});
    chk("slave select", 8'h00, {7'h00, ss});
    rd(`DFG_ADDR_CMP_CTRL, 8'h43, "cmp ctrl");
    rd(`DFG_ADDR_F_DIR, 8'hFF, "f dir kept");
    $display("test port f peripherals done");
    // can and pwm takeover with directions all input
    @(posedge clk_sys_in);
    per          <= 10'h063; // can_en, can_tx, pwm_d_en, pwm_d set
    g_ext        <= 6'h04;
    settle;
    chk("g oe_n can", 8'h2C, {2'b00, g_oen});
    chk("g out can", 8'h11, {2'b00, g_out & ~g_oen});
    chk("can rx high", 8'h01, {7'h00, can_rx});
    rd(`DFG_ADDR_G_DIR, 8'h3F, "g dir kept");
    @(posedge clk_sys_in);
    per.can_clk_sel <= 1'b1;
    per.can_bit_clk <= 1'b1;
    g_ext           <= 6'h00;
    settle;
    chk("g out bit clock", 8'h13, {2'b00, g_out & ~g_oen});
    chk("can rx low", 8'h00, {7'h00, can_rx});
    $display("test port g peripherals done");
    // general g pins and the input-only bit
    @(posedge clk_sys_in);
    per   <= '0;
    g_ext <= 6'h20;
    wr(`DFG_ADDR_G_LATCH, 8'h3F);
    wr(`DFG_ADDR_G_DIR, 8'h00);
    settle;
    chk("g oe_n gpio", 8'h20, {2'b00, g_oen});
    chk("g out gpio", 8'h1F, {2'b00, g_out & ~g_oen});
    rd(`DFG_ADDR_G_PINS, 8'h3F, "g pins bit5 high");
    chk("master_clear_input off", 8'h01, {7'h00, master_clear_input});
    @(posedge clk_sys_in);
    g_ext <= 6'h00;
    settle;
    rd(`DFG_ADDR_G_PINS, 8'h1F, "g pins bit5 low");
    @(posedge clk_sys_in);
    mcle <= 1'b1;
    settle;
    chk("master_clear_input on", 8'h00, {7'h00, master_clear_input});
    $display("test port g gpio done");
    // warm reset keeps latches, restores directions
    do_reset(1'b0);
    settle;
    rd(`DFG_ADDR_F_DIR, 8'hFF, "f dir warm");
    rd(`DFG_ADDR_F_LATCH, 8'h81, "f latch warm");
    rd(4'h9, 8'h00, "unmapped");
    $display("test warm reset done");
    complete_run;
  end
endmodule : tb_dfg_port

`default_nettype wire
